// File: design/capture_pkg.sv
// Purpose: Shared constants and state types for the three-unit input capture block.
// Assumes: 32-bit Avalon-MM register port, byte addresses, one word per register.
// Notes: All control fields reset to zero; the bus answers with waitrequest held high.
package capture_pkg;
   localparam int NUM_UNITS = 3;
   localparam int FIFO_DEPTH = 4;
   localparam int CNT_W = 16;
   localparam int NUM_SYNC = 31;
   localparam int DIV_W = 8;
   localparam logic [2:0] FIFO_FULL = 3'h4;
   localparam logic [CNT_W-1:0] CNT_MAX = 16'hffff;
   localparam logic [4:0] SEL_NONE = 5'h00;
   // Register byte offsets inside one unit, and the global interrupt block
   localparam logic [5:0] OFS_CTRL_ONE = 6'h00;
   localparam logic [5:0] OFS_CTRL_TWO = 6'h04;
   localparam logic [5:0] OFS_BUFFER = 6'h08;
   localparam logic [5:0] OFS_STATUS = 6'h0c;
   localparam logic [5:0] OFS_IRQ_STAT = 6'h30;
   localparam logic [5:0] OFS_IRQ_EN = 6'h34;
   localparam logic [5:0] OFS_IRQ_CLR = 6'h38;
   // Field positions
   localparam int C1_ENABLE = 0;
   localparam int C1_CLK_LSB = 1;
   localparam int C1_EDGE_LSB = 4;
   localparam int C1_CASCADE = 6;
   localparam int C2_SYNC_LSB = 0;
   localparam int C2_TRIG_STAT = 6;
   localparam int C2_TRIG_SEL = 7;
   localparam int ST_LEVEL_LSB = 16;
   localparam int ST_OVERFLOW = 19;
   // Counter clock sources
   localparam logic [2:0] CLK_SYS = 3'h0;
   localparam logic [2:0] CLK_DIV4 = 3'h1;
   localparam logic [2:0] CLK_DIV16 = 3'h2;
   localparam logic [2:0] CLK_DIV64 = 3'h3;
   localparam logic [2:0] CLK_DIV256 = 3'h4;
   localparam logic [2:0] CLK_EXT = 3'h5;
   // Capture edge choices
   localparam logic [1:0] EDGE_OFF = 2'h0;
   localparam logic [1:0] EDGE_RISE = 2'h1;
   localparam logic [1:0] EDGE_FALL = 2'h2;
   localparam logic [1:0] EDGE_BOTH = 2'h3;

   typedef struct packed {
      logic enable;
      logic [2:0] clk_sel;
      logic [1:0] edge_sel;
      logic cascade;
      logic [4:0] sync_source_select;
      logic trigger_mode_select;
      logic trigger_status;
      logic [CNT_W-1:0] capture_counter;
      logic [FIFO_DEPTH-1:0][CNT_W-1:0] fifo;
      logic [1:0] wr_ptr;
      logic [1:0] rd_ptr;
      logic [2:0] level;
      logic overflow;
   } unit_s;

   typedef struct packed {
      unit_s [NUM_UNITS-1:0] unit;
      logic [DIV_W-1:0] div;
      logic [NUM_UNITS-1:0] pin_prev;
      logic [NUM_SYNC-1:0] sync_prev;
      logic [2*NUM_UNITS-1:0] irq_stat;
      logic [2*NUM_UNITS-1:0] irq_en;
      logic waitreq;
      logic [31:0] rdata;
      logic irq;
   } state_s;

   localparam state_s STATE_RESET = '{unit: '0, div: '0, pin_prev: '0, sync_prev: '0,
      irq_stat: '0, irq_en: '0, waitreq: 1'b1, rdata: '0, irq: 1'b0};
endpackage

// File: design/input_capture_sync_trigger.sv
// Purpose: Three input capture units with private 16-bit time bases and 4-entry FIFOs.
// Assumes: Pins and sync sources are synchronous to ref_clk_in; Avalon-MM slave.
// Notes: Units 0 and 1 may be cascaded into one 32-bit unit; unit 2 stays 16-bit.
// Overview of operation
// [RQ1] Three independent units, each own counter, FIFO
// [RQ2] Neighbour pair cascades into 32 bits, all modes
// [RQ3] Four-entry FIFO per unit keeps timestamps
// [RQ4] Counter clocked by one of six sources
// [RQ5] Free run counts up, wraps to zero
// [RQ6] Counter advances only on selected source ticks
// [RQ7] Each capture pushes present counter value
// [RQ8] Sync mode captures at once when enabled
// [RQ9] Sync mode: sync event resets the counter
// [RQ10] Trigger mode: counter waits for sync event
// [RQ11] Select zero, trigger clear: free running
// [RQ12] Nonzero select: sync or trigger mode
// [RQ13] Trigger select bit picks trigger over sync
// [RQ14] Select field names the sync/trigger source
// [RQ15] Thirty-one selectable sync/trigger sources
// [RQ16] Select zero, trigger set: software starts capture
// [RQ17] Waiting trigger holds zero, sets status
//
// Decided for this implementation: the Avalon-MM interface to the registers and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module input_capture_sync_trigger
(
   // Clock and reset
   input wire logic ref_clk_in,
   input wire logic rst_in,
   // Avalon-MM slave
   input wire logic [5:0] avs_address_in,
   input wire logic avs_read_in,
   input wire logic avs_write_in,
   input wire logic [31:0] avs_writedata_in,
   input wire logic [3:0] avs_byteenable_in,
   output logic [31:0] avs_readdata_out,
   output logic avs_waitrequest_out,
   // Capture pins and time base sources
   input wire logic [capture_pkg::NUM_UNITS-1:0] capture_input_pin_in,
   input wire logic [capture_pkg::NUM_UNITS-1:0] ext_tick_in,
   input wire logic [capture_pkg::NUM_SYNC-1:0] sync_source_in,
   // Interrupt
   output logic irq_out
);

   capture_pkg::state_s st_q;
   capture_pkg::state_s st_d;
   capture_pkg::unit_s [capture_pkg::NUM_UNITS-1:0] ctl;
   capture_pkg::unit_s u0;
   logic [capture_pkg::NUM_UNITS-1:0] hi;
   logic [capture_pkg::NUM_UNITS-1:0] tick;
   logic [capture_pkg::NUM_UNITS-1:0] wrap;
   logic [capture_pkg::NUM_UNITS-1:0] cap;
   logic [capture_pkg::NUM_UNITS-1:0] sync_ev;
   logic [capture_pkg::NUM_UNITS-1:0] armed;
   logic [capture_pkg::NUM_UNITS-1:0] edge_hit;
   logic [capture_pkg::NUM_SYNC-1:0] sync_rise;
   logic [5:0] addr_w;
   logic [1:0] acc_unit;
   logic [5:0] acc_reg;
   logic unit_hit;
   logic req;
   logic accept;
   logic [31:0] rd_val;
   logic [31:0] wv;
   logic pin_now;
   logic pin_was;
   logic free0;
   int src;

   ////////////////////////////////////////////////////////////////////////////
   // Helpers

   // Six counter clock sources; codes above five never tick
   function automatic logic tick_of(input logic [2:0] sel, input logic [7:0] div,
                                    input logic ext);
      case (sel)
         capture_pkg::CLK_SYS: tick_of = 1'b1; // [RQ4]
         capture_pkg::CLK_DIV4: tick_of = &div[1:0];
         capture_pkg::CLK_DIV16: tick_of = &div[3:0];
         capture_pkg::CLK_DIV64: tick_of = &div[5:0];
         capture_pkg::CLK_DIV256: tick_of = &div;
         capture_pkg::CLK_EXT: tick_of = ext;
         default: tick_of = 1'b0;
      endcase
   endfunction

   // Byte-lane merge of a write into an old word
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                         input logic [3:0] be);
      logic [31:0] r;
      r = old;
      for (int b = 0; b < 4; b++)
      begin
         if (be[b])
         begin
            r[8*b +: 8] = wd[8*b +: 8];
         end
      end
      return r;
   endfunction

   function automatic logic [31:0] pack_one(input capture_pkg::unit_s u);
      logic [31:0] r;
      r = '0;
      r[capture_pkg::C1_ENABLE] = u.enable;
      r[capture_pkg::C1_CLK_LSB +: 3] = u.clk_sel;
      r[capture_pkg::C1_EDGE_LSB +: 2] = u.edge_sel;
      r[capture_pkg::C1_CASCADE] = u.cascade;
      return r;
   endfunction

   function automatic logic [31:0] pack_two(input capture_pkg::unit_s u);
      logic [31:0] r;
      r = '0;
      r[capture_pkg::C2_SYNC_LSB +: 5] = u.sync_source_select;
      r[capture_pkg::C2_TRIG_STAT] = u.trigger_status;
      r[capture_pkg::C2_TRIG_SEL] = u.trigger_mode_select;
      return r;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Bus decode

   assign sync_rise = sync_source_in & ~st_q.sync_prev;
   assign addr_w = {avs_address_in[5:2], 2'b00};
   assign acc_unit = addr_w[5:4];
   assign acc_reg = {2'b00, addr_w[3:0]};
   assign unit_hit = (acc_unit < 2'(capture_pkg::NUM_UNITS));
   assign req = avs_read_in | avs_write_in;
   // A request completes at the edge where waitrequest is seen low
   assign accept = req & ~st_q.waitreq;

   ////////////////////////////////////////////////////////////////////////////
   // Next state

   always_comb
   begin
      st_d = st_q;
      ctl = st_q.unit;
      hi = '0;
      tick = '0;
      wrap = '0;
      cap = '0;
      sync_ev = '0;
      armed = '0;
      edge_hit = '0;
      rd_val = '0;
      wv = '0;
      pin_now = 1'b0;
      pin_was = 1'b0;
      src = 0;
      st_d.div = st_q.div + 8'h01;
      st_d.pin_prev = capture_input_pin_in;
      st_d.sync_prev = sync_source_in;

      // Read data is prepared in the wait cycle, so it is stable at the accept edge
      if (unit_hit)
      begin
         case (acc_reg)
            capture_pkg::OFS_CTRL_ONE: rd_val = pack_one(st_q.unit[acc_unit]);
            capture_pkg::OFS_CTRL_TWO: rd_val = pack_two(st_q.unit[acc_unit]);
            capture_pkg::OFS_BUFFER:
            begin
               if (st_q.unit[acc_unit].level != 3'h0)
               begin
                  rd_val[15:0] = st_q.unit[acc_unit].fifo[st_q.unit[acc_unit].rd_ptr];
               end
            end
            capture_pkg::OFS_STATUS:
            begin
               rd_val[15:0] = st_q.unit[acc_unit].capture_counter;
               rd_val[capture_pkg::ST_LEVEL_LSB +: 3] = st_q.unit[acc_unit].level;
               rd_val[capture_pkg::ST_OVERFLOW] = st_q.unit[acc_unit].overflow;
            end
            default: rd_val = '0;
         endcase
      end
      else if (addr_w == capture_pkg::OFS_IRQ_STAT)
      begin
         rd_val[5:0] = st_q.irq_stat;
      end
      else if (addr_w == capture_pkg::OFS_IRQ_EN)
      begin
         rd_val[5:0] = st_q.irq_en;
      end
      st_d.waitreq = ~(req & st_q.waitreq);
      if (req & st_q.waitreq)
      begin
         st_d.rdata = avs_read_in ? rd_val : 32'h0000_0000;
      end

      // Software side effects, applied before hardware so hardware sets win
      if (accept & avs_write_in)
      begin
         if (unit_hit)
         begin
            case (acc_reg)
               capture_pkg::OFS_CTRL_ONE:
               begin
                  wv = merge(pack_one(st_q.unit[acc_unit]), avs_writedata_in,
                             avs_byteenable_in);
                  st_d.unit[acc_unit].enable = wv[capture_pkg::C1_ENABLE];
                  st_d.unit[acc_unit].clk_sel = wv[capture_pkg::C1_CLK_LSB +: 3];
                  st_d.unit[acc_unit].edge_sel = wv[capture_pkg::C1_EDGE_LSB +: 2];
                  st_d.unit[acc_unit].cascade = wv[capture_pkg::C1_CASCADE];
               end
               capture_pkg::OFS_CTRL_TWO:
               begin
                  wv = merge(pack_two(st_q.unit[acc_unit]), avs_writedata_in,
                             avs_byteenable_in);
                  st_d.unit[acc_unit].sync_source_select = wv[capture_pkg::C2_SYNC_LSB +: 5];
                  st_d.unit[acc_unit].trigger_mode_select = wv[capture_pkg::C2_TRIG_SEL];
                  // Software start, or re-arm by writing zero
                  st_d.unit[acc_unit].trigger_status = wv[capture_pkg::C2_TRIG_STAT]; // [RQ16]
               end
               capture_pkg::OFS_STATUS:
               begin
                  wv = merge(32'h0000_0000, avs_writedata_in, avs_byteenable_in);
                  if (wv[capture_pkg::ST_OVERFLOW])
                  begin
                     st_d.unit[acc_unit].overflow = 1'b0;
                  end
               end
               default: wv = '0;
            endcase
         end
         else if (addr_w == capture_pkg::OFS_IRQ_EN)
         begin
            wv = merge({26'h0, st_q.irq_en}, avs_writedata_in, avs_byteenable_in);
            st_d.irq_en = wv[5:0];
         end
         else if (addr_w == capture_pkg::OFS_IRQ_CLR)
         begin
            wv = merge(32'h0000_0000, avs_writedata_in, avs_byteenable_in);
            st_d.irq_stat = st_q.irq_stat & ~wv[5:0];
         end
      end

      // Reading the buffer pops the oldest entry
      if (accept & avs_read_in & unit_hit & (acc_reg == capture_pkg::OFS_BUFFER))
      begin
         if (st_q.unit[acc_unit].level != 3'h0)
         begin
            st_d.unit[acc_unit].rd_ptr = st_q.unit[acc_unit].rd_ptr + 2'h1;
            st_d.unit[acc_unit].level = st_q.unit[acc_unit].level - 3'h1;
         end
      end

      // Units in ascending order so a high half sees its low half's carry
      for (int i = 0; i < capture_pkg::NUM_UNITS; i++) // [RQ1]
      begin
         hi[i] = (i % 2 == 1) && st_q.unit[i - (i % 2)].cascade; // [RQ2]
         src = hi[i] ? i - 1 : i;
         // A high half follows every setting and the pin of its low half
         ctl[i] = st_q.unit[src];
         pin_now = capture_input_pin_in[src];
         pin_was = st_q.pin_prev[src];
         // Nonzero select names one of 31 sources; zero means none
         sync_ev[i] = (ctl[i].sync_source_select != capture_pkg::SEL_NONE) &&
                      sync_rise[5'(ctl[i].sync_source_select - 5'h01)]; // [RQ12][RQ14][RQ15]
         // Sync and free modes run at once; trigger modes wait for status
         armed[i] = ~ctl[i].trigger_mode_select | ctl[i].trigger_status; // [RQ8][RQ11][RQ13]
         if (hi[i])
         begin
            tick[i] = wrap[src]; // [RQ2]
         end
         else
         begin
            tick[i] = ctl[i].enable &&
                      tick_of(ctl[i].clk_sel, st_q.div, ext_tick_in[i]); // [RQ4][RQ6]
         end
         wrap[i] = tick[i] && armed[i] &&
                   (st_q.unit[i].capture_counter == capture_pkg::CNT_MAX) &&
                   !(~ctl[i].trigger_mode_select && sync_ev[i]);
         case (ctl[i].edge_sel)
            capture_pkg::EDGE_RISE: edge_hit[i] = pin_now & ~pin_was;
            capture_pkg::EDGE_FALL: edge_hit[i] = ~pin_now & pin_was;
            capture_pkg::EDGE_BOTH: edge_hit[i] = pin_now ^ pin_was;
            default: edge_hit[i] = 1'b0;
         endcase
         cap[i] = ctl[i].enable & armed[i] & edge_hit[i]; // [RQ8][RQ16]

         if (ctl[i].trigger_mode_select & ~ctl[i].trigger_status)
         begin
            st_d.unit[i].capture_counter = '0; // [RQ10][RQ17]
         end
         else if (~ctl[i].trigger_mode_select & sync_ev[i])
         begin
            st_d.unit[i].capture_counter = '0; // [RQ9]
         end
         else if (tick[i])
         begin
            // Natural 16-bit wrap back to zero
            st_d.unit[i].capture_counter = st_q.unit[i].capture_counter + 16'h0001; // [RQ5][RQ6]
         end

         // Hardware trigger arms the unit and wins over a same-cycle clear
         if (!hi[i] && ctl[i].trigger_mode_select && sync_ev[i])
         begin
            st_d.unit[i].trigger_status = 1'b1; // [RQ10][RQ17]
         end

         if (cap[i])
         begin
            if (st_d.unit[i].level == capture_pkg::FIFO_FULL)
            begin
               // Full FIFO keeps its old entries and drops the new one
               st_d.unit[i].overflow = 1'b1; // [RQ3]
               st_d.irq_stat[capture_pkg::NUM_UNITS + i] = 1'b1;
            end
            else
            begin
               st_d.unit[i].fifo[st_q.unit[i].wr_ptr] = st_q.unit[i].capture_counter; // [RQ7]
               st_d.unit[i].wr_ptr = st_q.unit[i].wr_ptr + 2'h1;
               st_d.unit[i].level = st_d.unit[i].level + 3'h1; // [RQ3]
               st_d.irq_stat[i] = 1'b1;
            end
         end
      end
      st_d.irq = |(st_d.irq_stat & st_d.irq_en);
   end

   always_ff @(posedge ref_clk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         st_q <= capture_pkg::STATE_RESET;
      end
      else
      begin
         st_q <= st_d;
      end
   end

   assign avs_readdata_out = st_q.rdata;
   assign avs_waitrequest_out = st_q.waitreq;
   assign irq_out = st_q.irq;

   ////////////////////////////////////////////////////////////////////////////
   // Checks on unit 0 and on the bus handshake

   assign u0 = st_q.unit[0];
   assign free0 = (u0.sync_source_select == capture_pkg::SEL_NONE) & ~u0.trigger_mode_select;

   default clocking cb @(posedge ref_clk_in);
   endclocking
   default disable iff (rst_in);

   chk_trig_hold_zero : assert property ( // [RQ17]
      u0.trigger_mode_select && !u0.trigger_status |=> u0.capture_counter == 16'h0000)
      else $error("counter not held at zero while waiting for trigger");

   chk_sync_reset_count : assert property ( // [RQ9]
      !u0.trigger_mode_select && sync_ev[0] |=> u0.capture_counter == 16'h0000)
      else $error("sync event did not reset counter");

   chk_free_wrap : assert property ( // [RQ5]
      free0 && u0.enable && u0.clk_sel == capture_pkg::CLK_SYS &&
      u0.capture_counter == 16'hffff |=> u0.capture_counter == 16'h0000)
      else $error("counter did not wrap to zero");

   chk_tick_only : assert property ( // [RQ6]
      free0 && u0.clk_sel == capture_pkg::CLK_DIV4 && st_q.div[1:0] != 2'h3
      |=> $stable(u0.capture_counter))
      else $error("counter moved without a source tick");

   chk_capture_value : assert property ( // [RQ7]
      cap[0] && u0.level != 3'h4 |=> u0.fifo[$past(u0.wr_ptr)] == $past(u0.capture_counter))
      else $error("captured value differs from counter");

   chk_fifo_overflow : assert property ( // [RQ3]
      cap[0] && u0.level == 3'h4 && !accept |=> u0.overflow && u0.level == 3'h4)
      else $error("full fifo did not flag overflow");

   chk_sync_capture : assert property ( // [RQ8]
      u0.sync_source_select != 5'h00 && !u0.trigger_mode_select && u0.enable &&
      edge_hit[0]
      |=> st_q.irq_stat[0] || st_q.irq_stat[3])
      else $error("sync mode edge not captured");

   chk_soft_trig_wait : assert property ( // [RQ16]
      u0.sync_source_select == 5'h00 && u0.trigger_mode_select && !u0.trigger_status
      |=> $stable(u0.wr_ptr))
      else $error("capture before software trigger");

   chk_trig_arm : assert property ( // [RQ10]
      u0.trigger_mode_select && sync_ev[0] |=> u0.trigger_status)
      else $error("trigger event did not set status");

   chk_cascade_carry : assert property ( // [RQ2]
      u0.cascade && wrap[0]
      |=> st_q.unit[1].capture_counter == $past(st_q.unit[1].capture_counter) + 16'h0001)
      else $error("high half missed low half carry");

   chk_bus_answer : assert property (
      req && avs_waitrequest_out |=> !avs_waitrequest_out)
      else $error("slave did not answer after one wait cycle");

   cov_free_capture : cover property (cap[0] && free0);
   cov_cascade_carry : cover property (u0.cascade && wrap[0]);
   cov_hw_trigger : cover property (u0.trigger_mode_select && sync_ev[0] && !u0.trigger_status);
   cov_overflow : cover property (cap[0] && u0.level == 3'h4);

endmodule
`default_nettype wire

// File: dv/pulse_source_model.sv
// Purpose: Far-side model driving the capture pins, tick lines and sync sources.
// Assumes: The bench asks for a one-cycle pulse per pin or sync line.
// Notes: Outputs are registered, so every line moves just after a rising edge.
`timescale 1ns/1ps
`default_nettype none
module pulse_source_model
(
   // Clock and reset
   input wire logic ref_clk_in,
   input wire logic rst_in,
   // Requests from the bench
   input wire logic [2:0] pin_req_in,
   input wire logic [30:0] sync_req_in,
   // Lines into the block
   output logic [2:0] pin_out,
   output logic [2:0] tick_out,
   output logic [30:0] sync_out
);
   logic [1:0] tick_cnt_q;

   // Ticks every fourth cycle, so external-clock deltas stay easy to predict
   always_ff @(posedge ref_clk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         tick_cnt_q <= 2'h0;
         pin_out <= 3'h0;
         tick_out <= 3'h0;
         sync_out <= 31'h0;
      end
      else
      begin
         tick_cnt_q <= tick_cnt_q + 2'h1;
         tick_out <= {3{tick_cnt_q == 2'h3}};
         pin_out <= pin_req_in;
         sync_out <= sync_req_in;
      end
   end
endmodule
`default_nettype wire

// File: dv/tb_input_capture_sync_trigger.sv
// Purpose: Self-checking bench for the three-unit capture block.
// Assumes: One wait cycle per bus access; unit 0 sits at offset 0x00.
// Notes: Rows compare timestamp deltas, so the divider phase never matters.
`timescale 1ns/1ps
`default_nettype none
module tb_input_capture_sync_trigger;
   typedef struct {logic [2:0] src; int gap; logic [15:0] delta;} row_s;
   logic clk;
   logic rst;
   logic [5:0] addr;
   logic rd;
   logic wr;
   logic [31:0] wdata;
   logic [31:0] rdata;
   logic waitreq;
   logic irq;
   logic [2:0] pin_req;
   logic [30:0] sync_req;
   logic [2:0] pins;
   logic [2:0] ticks;
   logic [30:0] syncs;
   logic [31:0] q;
   logic [31:0] a;
   int num_errors;
   int tests_run;
   row_s rows [6] = '{'{capture_pkg::CLK_SYS, 20, 16'h14}, '{capture_pkg::CLK_DIV4, 64, 16'h10},
      '{capture_pkg::CLK_DIV16, 64, 16'h4}, '{capture_pkg::CLK_DIV64, 128, 16'h2},
      '{capture_pkg::CLK_DIV256, 512, 16'h2}, '{capture_pkg::CLK_EXT, 64, 16'h10}};

   input_capture_sync_trigger u_input_capture_sync_trigger (.ref_clk_in(clk), .rst_in(rst),
      .avs_address_in(addr), .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wdata),
      .avs_byteenable_in(4'hf), .avs_readdata_out(rdata), .avs_waitrequest_out(waitreq),
      .capture_input_pin_in(pins), .ext_tick_in(ticks), .sync_source_in(syncs), .irq_out(irq));
   pulse_source_model u_pulse_source_model (.ref_clk_in(clk), .rst_in(rst), .pin_req_in(pin_req),
      .sync_req_in(sync_req), .pin_out(pins), .tick_out(ticks), .sync_out(syncs));

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp)
      begin
         num_errors++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // Request held until waitrequest is seen low; data taken at that edge
   task automatic bus(input logic w, input logic [5:0] ad, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk);
      addr <= ad;
      wdata <= d;
      rd <= !w;
      wr <= w;
      do
      begin
         @(posedge clk);
         n++;
      end
      while (waitreq !== 1'b0 && n < 50);
      if (n >= 50)
      begin
         num_errors++;
         $display("BAD t=%0t got=%h exp=%h", $time, waitreq, 1'b0);
      end
      q = rdata;
      rd <= 1'b0;
      wr <= 1'b0;
   endtask

   task automatic pulse();
      @(posedge clk);
      pin_req[0] <= 1'b1;
      @(posedge clk);
      pin_req[0] <= 1'b0;
   endtask

   // Sync rise on line b, then a capture shortly after it
   task automatic sync_cap(input int b);
      @(posedge clk);
      sync_req[b] <= 1'b1;
      @(posedge clk);
      sync_req[b] <= 1'b0;
      repeat (2) @(posedge clk);
      pulse();
      repeat (3) @(posedge clk);
      bus(1'b0, capture_pkg::OFS_BUFFER, 32'h0);
   endtask

   task automatic tally_and_finish();
      $display("tests_run=%0d num_errors=%0d", tests_run, num_errors);
      if (num_errors == 0 && tests_run > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   initial
   begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   // Whole run is about 67000 cycles, mostly the cascade wrap wait
   initial
   begin
      #720000;
      num_errors++;
      tally_and_finish();
   end

   initial
   begin
      rst = 1'b1;
      rd = 1'b0;
      wr = 1'b0;
      addr = 6'h00;
      wdata = 32'h0;
      pin_req = 3'h0;
      sync_req = 31'h0;
      num_errors = 0;
      tests_run = 0;
      repeat (5) @(posedge clk);
      chk(waitreq, 32'h1);
      chk(irq, 32'h0);
      rst <= 1'b0;
      // Every register of every unit, the irq block and the unmapped word
      for (int i = 0; i < 64; i += 4)
      begin
         bus(1'b0, 6'(i), 32'h0);
         chk(q, 32'h0);
      end
      $display("reset test done");
      foreach (rows[r])
      begin
         bus(1'b1, capture_pkg::OFS_CTRL_ONE, {26'h0, capture_pkg::EDGE_RISE, rows[r].src, 1'b1});
         pulse();
         repeat (rows[r].gap - 2) @(posedge clk);
         pulse();
         repeat (3) @(posedge clk);
         bus(1'b0, capture_pkg::OFS_STATUS, 32'h0);
         chk(32'(q[18:16]), 32'h2);
         bus(1'b0, capture_pkg::OFS_BUFFER, 32'h0);
         a = q;
         bus(1'b0, capture_pkg::OFS_BUFFER, 32'h0);
         chk({16'h0, q[15:0] - a[15:0]}, {16'h0, rows[r].delta});
      end
      $display("clock source test done");
      bus(1'b1, capture_pkg::OFS_CTRL_ONE, 32'h11);
      bus(1'b1, capture_pkg::OFS_IRQ_EN, 32'h9);
      repeat (5)
      begin
         pulse();
         repeat (3) @(posedge clk);
      end
      bus(1'b0, capture_pkg::OFS_STATUS, 32'h0);
      chk(32'(q[19:16]), 32'hc);
      chk(irq, 32'h1);
      bus(1'b0, capture_pkg::OFS_IRQ_STAT, 32'h0);
      chk(q & 32'h9, 32'h9);
      bus(1'b1, capture_pkg::OFS_IRQ_EN, 32'h0);
      repeat (2) @(posedge clk);
      chk(irq, 32'h0);
      bus(1'b1, capture_pkg::OFS_IRQ_EN, 32'h9);
      bus(1'b1, capture_pkg::OFS_IRQ_CLR, 32'h9);
      repeat (2) @(posedge clk);
      chk(irq, 32'h0);
      bus(1'b0, capture_pkg::OFS_BUFFER, 32'h0);
      a = q;
      // Oldest four kept, five cycles apart; the fifth was dropped
      repeat (3)
      begin
         bus(1'b0, capture_pkg::OFS_BUFFER, 32'h0);
         chk({16'h0, q[15:0] - a[15:0]}, 32'h5);
         a = q;
      end
      bus(1'b0, capture_pkg::OFS_BUFFER, 32'h0);
      chk(q, 32'h0);
      bus(1'b1, capture_pkg::OFS_STATUS, 32'h80000);
      $display("fifo and irq test done");
      foreach (rows[s])
      begin
         if (s < 2)
         begin
            bus(1'b1, capture_pkg::OFS_CTRL_TWO, (s == 0) ? 32'h1 : 32'h1f);
            sync_cap((s == 0) ? 30 : 0);
            chk(32'(q[15:0] < 16'h8), 32'h0);
            sync_cap((s == 0) ? 0 : 30);
            chk(32'(q[15:0] < 16'h8), 32'h1);
         end
      end
      $display("sync test done");
      bus(1'b1, capture_pkg::OFS_CTRL_TWO, 32'h83);
      pulse();
      repeat (6) @(posedge clk);
      bus(1'b0, capture_pkg::OFS_STATUS, 32'h0);
      chk(q, 32'h0);
      sync_cap(2);
      chk(32'(q[15:0] < 16'h8), 32'h1);
      bus(1'b0, capture_pkg::OFS_CTRL_TWO, 32'h0);
      chk(q, 32'hc3);
      $display("trigger test done");
      bus(1'b1, capture_pkg::OFS_CTRL_TWO, 32'h80);
      pulse();
      repeat (6) @(posedge clk);
      bus(1'b0, capture_pkg::OFS_STATUS, 32'h0);
      chk(q, 32'h0);
      bus(1'b1, capture_pkg::OFS_CTRL_TWO, 32'hc0);
      pulse();
      repeat (3) @(posedge clk);
      bus(1'b0, capture_pkg::OFS_STATUS, 32'h0);
      chk(32'(q[18:16]), 32'h1);
      chk(32'(q[15:0] != 16'h0), 32'h1);
      $display("software trigger test done");
      // Two captures one full wrap plus two ticks apart: the high half must count one carry
      bus(1'b1, capture_pkg::OFS_CTRL_TWO, 32'h0);
      bus(1'b1, capture_pkg::OFS_CTRL_ONE, 32'h51);
      pulse();
      repeat (65536) @(posedge clk);
      pulse();
      repeat (3) @(posedge clk);
      repeat (2) bus(1'b0, capture_pkg::OFS_BUFFER, 32'h0);
      a = q;
      bus(1'b0, capture_pkg::OFS_BUFFER, 32'h0);
      chk({16'h0, q[15:0] - a[15:0]}, 32'h2);
      bus(1'b0, 6'h10 + capture_pkg::OFS_BUFFER, 32'h0);
      chk(q, 32'h0);
      bus(1'b0, 6'h10 + capture_pkg::OFS_BUFFER, 32'h0);
      chk(q, 32'h1);
      $display("cascade test done");
      tally_and_finish();
   end
endmodule
`default_nettype wire
